// ===== sfis_fifo.sv
// Measurement sample FIFO with flags, tick delay, mode bit and interrupt source
`timescale 1ns/100ps
module sfis_fifo
  import sfis_pkg::*;
(
  input wire logic ref_clk, // System clock, 50 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic sample_valid, // One-cycle tick: new sample from the engine
  input wire logic [SAMPLE_W-1:0] sample_data, // Pressure 3 bytes then temperature 2 bytes
  input wire logic active_mode, // 1 active, 0 standby
  input wire logic link_clk, // Host access clock
  input wire logic link_rst_n, // Link domain reset, synchronous, active low
  input wire logic lk_req_valid, // Host offers a register access
  input wire logic lk_req_write, // 1 write, 0 read
  input wire logic [7:0] lk_addr, // Register address
  input wire logic [7:0] lk_wdata, // Write data
  output logic lk_req_ready, // Link can take an access
  output logic [7:0] lk_rdata, // Read data
  output logic lk_rdata_valid, // One-cycle pulse with read data
  output logic overflow_flag, // FIFO holds 32 samples
  output logic watermark_flag, // Count equals watermark level
  output logic fifo_interrupt_bit // Sticky FIFO interrupt source
);

  // ********************************
  // Byte selection
  // ********************************
  function automatic logic [7:0] byte_of(input logic [SAMPLE_W-1:0] smp,
                                         input logic [BIDX_W-1:0] idx);
    logic [7:0] b;
    b = BYTE_ZERO;
    unique case (idx)
      3'h0: b = smp[39:32];
      3'h1: b = smp[31:24];
      3'h2: b = smp[23:16];
      3'h3: b = smp[15:8];
      3'h4: b = smp[7:0];
      default: b = BYTE_ZERO;
    endcase
    return b;
  endfunction : byte_of

  // ********************************
  // Link side of the crossing
  // ********************************
  logic hold_write_q;
  logic [7:0] hold_addr_q;
  logic [7:0] hold_wdata_q;
  logic req_tgl_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic ack_seen_q;
  logic ack_tgl_q;
  logic [7:0] rdata_hold_q;

  wire lk_take = lk_req_valid & lk_req_ready;
  wire lk_done = ack_s2_q != ack_seen_q;

  // Hold registers stay still until the answer returns, so the core may read them
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      lk_req_ready <= 1'b1;
      hold_write_q <= 1'b0;
      hold_addr_q <= BYTE_ZERO;
      hold_wdata_q <= BYTE_ZERO;
      req_tgl_q <= 1'b0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_seen_q <= 1'b0;
      lk_rdata <= BYTE_ZERO;
      lk_rdata_valid <= 1'b0;
    end else begin
      ack_s1_q <= ack_tgl_q;
      ack_s2_q <= ack_s1_q;
      ack_seen_q <= ack_s2_q;
      lk_rdata_valid <= lk_done & ~hold_write_q;
      if (lk_done) begin
        lk_req_ready <= 1'b1;
        lk_rdata <= hold_write_q ? lk_rdata : rdata_hold_q;
      end else if (lk_take) begin
        lk_req_ready <= 1'b0;
        hold_write_q <= lk_req_write;
        hold_addr_q <= lk_addr;
        hold_wdata_q <= lk_wdata;
        req_tgl_q <= ~req_tgl_q;
      end
    end
  end

  // ********************************
  // Core side of the crossing
  // ********************************
  logic req_s1_q;
  logic req_s2_q;
  logic req_seen_q;

  wire cr_req = req_s2_q != req_seen_q;
  wire cr_rd = cr_req & ~hold_write_q;
  wire cr_wr = cr_req & hold_write_q;
  logic [7:0] rd_mux;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_seen_q <= 1'b0;
      ack_tgl_q <= 1'b0;
      rdata_hold_q <= BYTE_ZERO;
    end else begin
      req_s1_q <= req_tgl_q;
      req_s2_q <= req_s1_q;
      req_seen_q <= req_s2_q;
      if (cr_req) begin
        ack_tgl_q <= ~ack_tgl_q;
        rdata_hold_q <= rd_mux;
      end
    end
  end

  // ********************************
  // FIFO state
  // ********************************
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] count_q;
  logic [BIDX_W-1:0] byte_idx_q;
  logic [1:0] mode_q;
  logic [WMRK_W-1:0] wmrk_q;
  logic active_q;
  logic tick_run_q;
  logic [7:0] tick_q;
  logic [SAMPLE_W-1:0] last_q;
  logic [SAMPLE_W-1:0] head;

  wire fifo_on = (mode_q == MODE_CIRC) | (mode_q == MODE_STOP);
  wire not_empty = count_q != CNT_EMPTY;
  wire is_full = count_q == CNT_FULL;
  wire [7:0] head_byte = not_empty ? byte_of(head, byte_idx_q) : BYTE_ZERO;
  wire data_addr = (hold_addr_q == ADDR_P_HIGH) | (hold_addr_q == ADDR_FIFO_READ_PORT);
  wire data_rd = cr_rd & fifo_on & data_addr;
  wire pop = data_rd & not_empty & (byte_idx_q == BIDX_LAST);
  wire room = ~is_full | pop;
  // Samples are taken regardless of a read in flight; a pop in the same cycle makes room
  wire push_raw = fifo_on & sample_valid & (room | (mode_q == MODE_CIRC));
  wire overwrite = push_raw & ~room;

  // ********************************
  // Configuration writes
  // ********************************
  wire cfg_wr = cr_wr & (hold_addr_q == ADDR_FIFO_CONFIGURATION);
  wire [1:0] new_mode = hold_wdata_q[CFG_MODE_MSB:CFG_MODE_LSB];
  wire [WMRK_W-1:0] new_wmrk = hold_wdata_q[WMRK_W-1:0];
  wire new_on = (new_mode == MODE_CIRC) | (new_mode == MODE_STOP);
  // A direct swap between the two running modes is dropped rather than half-applied
  wire mode_swap = fifo_on & new_on & (new_mode != mode_q);
  wire mode_ok = cfg_wr & active_mode & (new_mode != MODE_UNUSED) & ~mode_swap;
  wire wmrk_ok = cfg_wr & ~active_mode;
  wire [1:0] mode_d = mode_ok ? new_mode : mode_q;
  wire [WMRK_W-1:0] wmrk_d = wmrk_ok ? new_wmrk : wmrk_q;
  wire go_active = active_mode & ~active_q;
  wire flush = (mode_ok & (new_mode == MODE_OFF)) | go_active;
  wire push = push_raw & ~flush;

  logic [CNT_W-1:0] count_d;
  always_comb begin
    if (flush) begin
      count_d = CNT_EMPTY;
    end else begin
      count_d = count_q + CNT_W'(push & room) - CNT_W'(pop);
    end
  end

  wire ovf_d = count_d == CNT_FULL;
  wire wmrk_flag_d = (wmrk_d != WMRK_OFF) & (count_d == {1'b0, wmrk_d[WMRK_W-2:0]}) &
                     ~wmrk_d[WMRK_W-1] | (wmrk_d == CNT_FULL) & ovf_d;
  // Each flag has its own edge, so one rising while the other stands still sets the bit
  wire src_rise = (ovf_d & ~overflow_flag) | (wmrk_flag_d & ~watermark_flag);
  wire stat_rd = cr_rd & (hold_addr_q == ADDR_FIFO_STATUS);
  wire ovf_event = push & (count_d == CNT_FULL);
  wire drained = pop & (count_d == CNT_EMPTY);

  sfis_store u_store (
    .ref_clk(ref_clk),
    .wr_en(push),
    .wr_addr(wr_ptr_q),
    .wr_data(sample_data),
    .rd_addr(rd_ptr_q),
    .rd_data(head)
  );

  // ********************************
  // State update
  // ********************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= CNT_EMPTY;
      byte_idx_q <= BIDX_FIRST;
      mode_q <= MODE_OFF;
      wmrk_q <= WMRK_OFF;
      active_q <= 1'b0;
      overflow_flag <= 1'b0;
      watermark_flag <= 1'b0;
      fifo_interrupt_bit <= 1'b0;
    end else begin
      mode_q <= mode_d;
      wmrk_q <= wmrk_d;
      active_q <= active_mode;
      count_q <= count_d;
      overflow_flag <= ovf_d;
      watermark_flag <= wmrk_flag_d;
      // Set wins over the clear from a status read in the same cycle
      fifo_interrupt_bit <= src_rise | (fifo_interrupt_bit & ~stat_rd);
      if (flush) begin
        wr_ptr_q <= '0;
        rd_ptr_q <= '0;
        byte_idx_q <= BIDX_FIRST;
      end else begin
        wr_ptr_q <= push ? wr_ptr_q + PTR_ONE : wr_ptr_q;
        rd_ptr_q <= (pop | (overwrite & ~flush)) ? rd_ptr_q + PTR_ONE : rd_ptr_q;
        if (overwrite | pop) begin
          byte_idx_q <= BIDX_FIRST;
        end else if (data_rd & not_empty) begin
          byte_idx_q <= byte_idx_q + BIDX_ONE;
        end
      end
    end
  end

  // Tick delay: begins at overflow, saturates rather than wrapping to a misleading small value
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tick_run_q <= 1'b0;
      tick_q <= BYTE_ZERO;
      last_q <= '0;
    end else begin
      if (sample_valid) begin
        last_q <= sample_data;
      end
      if (flush | drained) begin
        tick_run_q <= 1'b0;
        tick_q <= BYTE_ZERO;
      end else begin
        // A wrap keeps the count going; only the first overflow starts it
        if (ovf_event | overwrite) begin
          tick_run_q <= 1'b1;
        end
        if (tick_run_q & sample_valid & (tick_q != TICK_MAX)) begin
          tick_q <= tick_q + TICK_ONE;
        end
      end
    end
  end

  // ********************************
  // Read decode
  // ********************************
  wire [BIDX_W-1:0] out_idx = BIDX_W'(hold_addr_q - ADDR_P_HIGH);
  wire out_addr = (hold_addr_q >= ADDR_P_HIGH) & (hold_addr_q <= ADDR_T_LOW);

  always_comb begin
    rd_mux = BYTE_ZERO;
    unique case (1'b1)
      out_addr & fifo_on: begin
        rd_mux = (hold_addr_q == ADDR_P_HIGH) ? head_byte : BYTE_ZERO;
      end
      out_addr & ~fifo_on: rd_mux = byte_of(last_q, out_idx);
      hold_addr_q == ADDR_FIFO_STATUS: rd_mux = {overflow_flag, watermark_flag, count_q};
      hold_addr_q == ADDR_FIFO_READ_PORT: rd_mux = fifo_on ? head_byte : BYTE_ZERO;
      hold_addr_q == ADDR_FIFO_CONFIGURATION: rd_mux = {mode_q, wmrk_q};
      hold_addr_q == ADDR_POST_OVERFLOW_TICK_COUNT: rd_mux = tick_q;
      hold_addr_q == ADDR_OPERATING_STATE: rd_mux = {OPERATING_STATE_PAD, active_mode};
      hold_addr_q == ADDR_INTERRUPT_ORIGIN: begin
        rd_mux = fifo_interrupt_bit ? FIFO_INTERRUPT_BIT_MASK : BYTE_ZERO;
      end
      default: rd_mux = BYTE_ZERO;
    endcase
  end

endmodule : sfis_fifo

// ===== sfis_fifo_props.sv
// Concurrent checks on the sample FIFO ports
`timescale 1ns/100ps
module sfis_fifo_props (
  input wire logic ref_clk, // System clock
  input wire logic rst_n, // System reset, active low
  input wire logic sample_valid, // Sample tick
  input wire logic active_mode, // Active level
  input wire logic link_clk, // Link clock
  input wire logic link_rst_n, // Link reset, active low
  input wire logic lk_req_valid, // Access offered
  input wire logic lk_req_ready, // Access can be taken
  input wire logic [7:0] lk_rdata, // Read data
  input wire logic lk_rdata_valid, // Read answer pulse
  input wire logic overflow_flag, // Full flag
  input wire logic watermark_flag, // Watermark flag
  input wire logic fifo_interrupt_bit // Sticky source bit
);
  // ****************
  // Link handshake
  // ****************
  sequence s_take;
    lk_req_valid && lk_req_ready;
  endsequence
  sequence s_answer;
    !lk_req_ready ##[1:20] lk_req_ready;
  endsequence
  a_ready_drop: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    s_take |=> !lk_req_ready) else $error("ready stayed high after a take");
  a_answer_bound: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    s_take |=> s_answer) else $error("access not answered in time");
  a_rvalid_pulse: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    lk_rdata_valid |=> !lk_rdata_valid) else $error("read pulse too long");
  a_rvalid_ready: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    lk_rdata_valid |-> lk_req_ready && !$past(lk_req_ready))
    else $error("read pulse apart from ready rise");
  a_rdata_hold: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    !lk_rdata_valid |-> $stable(lk_rdata)) else $error("read data moved");
  // ****************
  // Flags and source bit
  // ****************
  a_int_on_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(overflow_flag) || $rose(watermark_flag) |-> fifo_interrupt_bit)
    else $error("source bit missed a flag rise");
  a_int_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(fifo_interrupt_bit) |-> overflow_flag || watermark_flag)
    else $error("source bit set without a flag");
  a_int_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fifo_interrupt_bit && lk_req_ready && $past(lk_req_ready) |=> fifo_interrupt_bit)
    else $error("source bit cleared without a read");
  a_ovf_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(overflow_flag) |-> $past(sample_valid)) else $error("overflow without a sample");
  a_flush_flags: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(active_mode) |=> !overflow_flag && !watermark_flag)
    else $error("flags kept over a flush");
endmodule : sfis_fifo_props

// ===== sfis_host.sv
// Host model issuing one register access at a time over the link
`timescale 1ns/100ps
module sfis_host (
  input wire logic link_clk, // Link clock
  input wire logic lk_req_ready, // Device can take an access
  input wire logic [7:0] lk_rdata, // Read answer
  output logic lk_req_valid, // Access offered
  output logic lk_req_write, // 1 write
  output logic [7:0] lk_addr, // Register address
  output logic [7:0] lk_wdata // Write data
);
  int timeouts = 0;
  initial begin
    lk_req_valid = 1'b0;
    lk_req_write = 1'b0;
    lk_addr = 8'h00;
    lk_wdata = 8'h00;
  end
  // Request held until taken, answer taken on the edge that ready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] r);
    int n;
    n = 0;
    @(posedge link_clk);
    lk_req_valid <= 1'b1;
    lk_req_write <= w;
    lk_addr <= a;
    lk_wdata <= d;
    do @(posedge link_clk); while (!lk_req_ready);
    lk_req_valid <= 1'b0;
    // Released lines change so stale values never look valid
    lk_addr <= ~a;
    lk_wdata <= ~d;
    do begin
      @(posedge link_clk);
      n++;
    end while (!lk_req_ready && n < 40);
    if (!lk_req_ready) begin
      timeouts++;
    end
    r = lk_rdata;
  endtask : xfer
endmodule : sfis_host

// ===== sfis_pkg.sv
// Constants shared by the sample FIFO block and its storage array
package sfis_pkg;

  // ********************************
  // Geometry
  // ********************************
  localparam int FIFO_DEPTH = 32;
  localparam int SAMPLE_W = 40;
  localparam int PTR_W = 5;
  localparam int CNT_W = 6;
  localparam int BIDX_W = 3;
  localparam int WMRK_W = 6;

  localparam logic [CNT_W-1:0] CNT_EMPTY = 6'h00;
  localparam logic [CNT_W-1:0] CNT_FULL = 6'h20;
  localparam logic [PTR_W-1:0] PTR_ONE = 5'h01;
  localparam logic [BIDX_W-1:0] BIDX_FIRST = 3'h0;
  localparam logic [BIDX_W-1:0] BIDX_ONE = 3'h1;
  localparam logic [BIDX_W-1:0] BIDX_LAST = 3'h4;

  // ********************************
  // Register addresses
  // ********************************
  localparam logic [7:0] ADDR_P_HIGH = 8'h01;
  localparam logic [7:0] ADDR_P_MID = 8'h02;
  localparam logic [7:0] ADDR_P_LOW = 8'h03;
  localparam logic [7:0] ADDR_T_HIGH = 8'h04;
  localparam logic [7:0] ADDR_T_LOW = 8'h05;
  localparam logic [7:0] ADDR_FIFO_STATUS = 8'h0d;
  localparam logic [7:0] ADDR_FIFO_READ_PORT = 8'h0e;
  localparam logic [7:0] ADDR_FIFO_CONFIGURATION = 8'h0f;
  localparam logic [7:0] ADDR_POST_OVERFLOW_TICK_COUNT = 8'h10;
  localparam logic [7:0] ADDR_OPERATING_STATE = 8'h11;
  localparam logic [7:0] ADDR_INTERRUPT_ORIGIN = 8'h12;

  // ********************************
  // Fields and reset values
  // ********************************
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_CIRC = 2'h1;
  localparam logic [1:0] MODE_STOP = 2'h2;
  localparam logic [1:0] MODE_UNUSED = 2'h3;
  localparam int CFG_MODE_MSB = 7;
  localparam int CFG_MODE_LSB = 6;
  localparam logic [WMRK_W-1:0] WMRK_OFF = 6'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] TICK_MAX = 8'hff;
  localparam logic [7:0] TICK_ONE = 8'h01;
  localparam logic [7:0] FIFO_INTERRUPT_BIT_MASK = 8'h40;
  localparam logic [6:0] OPERATING_STATE_PAD = 7'h00;

endpackage : sfis_pkg

// ===== sfis_store.sv
// Sample storage array: one synchronous write port, one combinational read port
`timescale 1ns/100ps
module sfis_store
  import sfis_pkg::*;
(
  input wire logic ref_clk, // System clock
  input wire logic wr_en, // Store one sample this cycle
  input wire logic [PTR_W-1:0] wr_addr, // Slot to write
  input wire logic [SAMPLE_W-1:0] wr_data, // Sample to store
  input wire logic [PTR_W-1:0] rd_addr, // Slot to look at
  output logic [SAMPLE_W-1:0] rd_data // Sample in that slot
);

  // ********************************
  // Array
  // ********************************
  // No reset on the array: the count and pointers decide what is valid
  logic [SAMPLE_W-1:0] mem_q [FIFO_DEPTH];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem_q[rd_addr];

endmodule : sfis_store

// ===== test_sample_fifo_with_int_status.sv
// Bench: pushes samples and reaches the registers through the host model
`timescale 1ns/100ps
`define CHK(g, e) begin \
  checked++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module test_sample_fifo_with_int_status;
  import sfis_pkg::*;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic link_rst_n = 1'b0;
  logic sample_valid = 1'b0;
  logic [SAMPLE_W-1:0] sample_data = '0;
  logic active_mode = 1'b0;
  logic lk_req_valid, lk_req_write, lk_req_ready, lk_rdata_valid;
  logic [7:0] lk_addr, lk_wdata, lk_rdata;
  logic overflow_flag, watermark_flag, fifo_interrupt_bit;
  int bad_count = 0;
  int checked = 0;
  int nk = 0;
  always #10 ref_clk = ~ref_clk;
  initial begin
    #3;
    forever #6 link_clk = ~link_clk;
  end
  sfis_fifo sfis_fifo_inst (.ref_clk, .rst_n, .sample_valid, .sample_data, .active_mode,
    .link_clk, .link_rst_n, .lk_req_valid, .lk_req_write, .lk_addr, .lk_wdata, .lk_req_ready,
    .lk_rdata, .lk_rdata_valid, .overflow_flag, .watermark_flag, .fifo_interrupt_bit);
  sfis_host sfis_host_inst (.link_clk, .lk_req_ready, .lk_rdata, .lk_req_valid,
    .lk_req_write, .lk_addr, .lk_wdata);
  // ****************
  // Helpers
  // ****************
  function automatic logic [7:0] sb(int k, int j);
    return 8'(k * 5 + j + 1);
  endfunction : sb
  task automatic push(int n);
    repeat (n) begin
      @(negedge ref_clk);
      sample_valid = 1'b1;
      sample_data = {sb(nk, 0), sb(nk, 1), sb(nk, 2), sb(nk, 3), sb(nk, 4)};
      nk++;
      @(negedge ref_clk);
      sample_valid = 1'b0;
    end
  endtask : push
  task automatic wr(logic [7:0] a, logic [7:0] d);
    logic [7:0] v;
    sfis_host_inst.xfer(1'b1, a, d, v);
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] e);
    logic [7:0] v;
    sfis_host_inst.xfer(1'b0, a, 8'h00, v);
    `CHK(v, e)
  endtask : rd
  task automatic test_done;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  // ****************
  // Sequence
  // ****************
  initial begin
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    link_rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    rd(ADDR_OPERATING_STATE, 8'h00);
    rd(ADDR_POST_OVERFLOW_TICK_COUNT, 8'h00);
    wr(ADDR_FIFO_CONFIGURATION, 8'h43);
    rd(ADDR_FIFO_CONFIGURATION, 8'h03);
    push(1);
    rd(ADDR_FIFO_STATUS, 8'h00);
    @(negedge ref_clk);
    active_mode = 1'b1;
    rd(ADDR_OPERATING_STATE, 8'h01);
    wr(ADDR_FIFO_CONFIGURATION, 8'h40);
    rd(ADDR_FIFO_CONFIGURATION, 8'h43);
    push(3);
    `CHK(watermark_flag, 1'b1)
    rd(ADDR_INTERRUPT_ORIGIN, FIFO_INTERRUPT_BIT_MASK);
    rd(ADDR_FIFO_STATUS, 8'h43);
    `CHK(fifo_interrupt_bit, 1'b0)
    `CHK(watermark_flag, 1'b1)
    fork
      for (int j = 0; j < 5; j++) rd(ADDR_P_HIGH, sb(1, j));
      push(1);
    join
    rd(ADDR_P_MID, 8'h00);
    rd(ADDR_FIFO_STATUS, 8'h43);
    push(29);
    `CHK(overflow_flag, 1'b1)
    push(1);
    rd(ADDR_FIFO_STATUS, 8'ha0);
    rd(ADDR_POST_OVERFLOW_TICK_COUNT, 8'h01);
    for (int i = 0; i < 160; i++) rd(ADDR_FIFO_READ_PORT, sb(3 + i / 5, i % 5));
    rd(ADDR_P_HIGH, 8'h00);
    rd(ADDR_POST_OVERFLOW_TICK_COUNT, 8'h00);
    rd(ADDR_FIFO_STATUS, 8'h00);
    wr(ADDR_FIFO_CONFIGURATION, 8'h80);
    wr(ADDR_FIFO_CONFIGURATION, 8'hc0);
    rd(ADDR_FIFO_CONFIGURATION, 8'h43);
    wr(ADDR_FIFO_CONFIGURATION, 8'h00);
    wr(ADDR_FIFO_CONFIGURATION, 8'h80);
    rd(ADDR_FIFO_CONFIGURATION, 8'h83);
    push(33);
    rd(ADDR_FIFO_STATUS, 8'ha0);
    rd(ADDR_P_HIGH, sb(35, 0));
    @(negedge ref_clk);
    active_mode = 1'b0;
    @(negedge ref_clk);
    active_mode = 1'b1;
    @(negedge ref_clk);
    `CHK(overflow_flag, 1'b0)
    push(3);
    `CHK(watermark_flag, 1'b1)
    wr(ADDR_FIFO_CONFIGURATION, 8'h00);
    `CHK(watermark_flag, 1'b0)
    rd(ADDR_FIFO_STATUS, 8'h00);
    rd(8'h20, 8'h00);
    `CHK(sfis_host_inst.timeouts, 0)
    test_done;
  end
  initial begin
    #400000;
    bad_count++;
    test_done;
  end
endmodule : test_sample_fifo_with_int_status
bind sfis_fifo sfis_fifo_props sfis_fifo_props_inst (.ref_clk, .rst_n, .sample_valid,
  .active_mode, .link_clk, .link_rst_n, .lk_req_valid, .lk_req_ready, .lk_rdata,
  .lk_rdata_valid, .overflow_flag, .watermark_flag, .fifo_interrupt_bit);
